// file: rtl/wake_seq_consts.vh
// Constants for the power-mode exit and reset sequencer.
// Included by the sequencer and its delay counter; definitions only.
`ifndef WAKE_SEQ_CONSTS_VH
`define WAKE_SEQ_CONSTS_VH
// Clock period in ns.
`define CLK_PERIOD_NS 10
// Oscillator start-up timer period in ns.
`define OST_TIME_NS 10240
// PLL lock time in ns.
`define PLL_LOCK_TIME_NS 2000
// CPU-preparation delay in ns.
`define CPU_PREP_TIME_NS 100
// Internal oscillator settle delay in ns.
`define INTOSC_SETTLE_TIME_NS 1000
// Cycle counts derived from the times, least times rounded up.
`define OST_CYCLES ((`OST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_CYCLES ((`PLL_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PREP_CYCLES ((`CPU_PREP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYCLES ((`INTOSC_SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 12
// Primary clock configuration codes.
`define PCLK_W 3
`define PCLK_CRYSTAL 3'h0
`define PCLK_HS_CRYSTAL 3'h1
`define PCLK_CRYSTAL_PLL 3'h2
`define PCLK_HS_PLL 3'h3
`define PCLK_EXTERNAL 3'h4
`define PCLK_INTERNAL 3'h5
// Clock-select codes.
`define SEL_PRIMARY 2'h0
`define SEL_SECONDARY 2'h1
`define SEL_INTERNAL 2'h2
// Power mode codes.
`define PM_RUN 2'h0
`define PM_PRIMARY_IDLE_MODE 2'h1
`define PM_IDLE_OTHER 2'h2
`define PM_SLEEP 2'h3
// Reset control register fields.
`define RC_BROWNOUT 0
`define RC_POWERON 1
`define RC_POWERDOWN 2
`define RC_TIMEOUT 3
`define RC_RESET_INSTR 4
`define RC_UNUSED 5
`define RC_SW_BROWNOUT_ENABLE 6
`define RC_IRQ_PRIORITY_ENABLE 7
`define RC_RESET_VALUE 8'h5c
// Reset cause codes.
`define CAUSE_W 3
`define CAUSE_POWER_ON 3'h0
`define CAUSE_MASTER_CLEAR_PIN_RUN 3'h1
`define CAUSE_MASTER_CLEAR_PIN_PM 3'h2
`define CAUSE_WATCHDOG 3'h3
`define CAUSE_BROWNOUT 3'h4
`define CAUSE_RESET_INSTR 3'h5
`define CAUSE_STACK_FULL 3'h6
`define CAUSE_STACK_UNDER 3'h7
`endif

// file: rtl/delay_counter.v
// Down-counter that times one delay interval.
// Assumes a load pulse with a nonzero count; done is a level after expiry.
`timescale 1ns/1ns
`include "wake_seq_consts.vh"
module delay_counter (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire load_in,
  input wire [`CNT_W-1:0] count_in,
  output wire done_out
);
  reg [`CNT_W-1:0] count;
  reg running;
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count <= {`CNT_W{1'b0}};
      running <= 1'b0;
    end else if (load_in) begin
      count <= count_in;
      running <= 1'b1;
    end else if (running && count != {`CNT_W{1'b0}}) begin
      count <= count - {{(`CNT_W-1){1'b0}}, 1'b1};
    end
  end
  assign done_out = running && !load_in && (count == {`CNT_W{1'b0}});
endmodule // delay_counter

// file: rtl/wake_reset_sequencer.v
// Power-mode exit and reset sequencer: holds the core off after reset or wake.
// Assumes only the master clear pin passes a three-stage synchroniser here; other reset and wake sources arrive synchronous.
// Summary of operation
// RL1: A watchdog expiry in sleep or any idle mode wakes the device, not resets it.
// RL2: A watchdog expiry while running code causes a watchdog reset.
// RL3: After reset the core is held by the start-up timer until the primary clock is ready.
// RL4: With two-speed start-up or the clock monitor, execution starts once reset clears.
// RL5: The internal clock runs code until the primary is ready or a power mode cuts it off.
// RL6: The start-up timer is skipped from primary idle and for non-crystal primary clocks.
// RL7: Even without a start-up timer, wake still imposes the CPU-preparation delay.
// RL8: The CPU-preparation delay runs alongside any other delay, not after it.
// RL9: Wake delay is the timer, timer plus PLL lock, or the preparation delay alone, by clock.
// RL10: Secondary to internal clock runs during settling; internal to internal has none.
// RL11: Eight reset causes are told apart.
// RL12: The low five flags are cleared by their event; software writes can set brown-out, power-on and reset-instruction, not power-down or timeout.
// RL13: The flag bits are readable together to tell the last reset type.
// RL14: The register also holds interrupt-priority and software brown-out enable bits.
// RL15: A watchdog wake enters the run mode the clock-select bits name.
// RL16: Software reads brown-out as brown-out flag 0 with power-on flag 1.
// RL17: Flags update in the cycle a reset is taken and hold until software writes them.
`timescale 1ns/1ns
`include "wake_seq_consts.vh"
module wake_reset_sequencer (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire por_event_in,
  input wire brownout_event_in,
  input wire master_clear_pin_n_in,
  input wire reset_instr_in,
  input wire stack_full_in,
  input wire stack_underflow_in,
  input wire watchdog_expire_in,
  input wire wake_irq_in,
  input wire sleep_cmd_in,
  input wire idle_enable_in,
  input wire [1:0] clock_select_bits_in,
  input wire [`PCLK_W-1:0] primary_cfg_in,
  input wire two_speed_en_in,
  input wire fail_safe_en_in,
  input wire reset_control_reg_wr_in,
  input wire [7:0] reset_control_reg_wdata_in,
  input wire sbor_available_in,
  output reg core_run_out,
  output reg core_reset_out,
  output reg [1:0] run_clock_out,
  output reg primary_clock_ready_flag_out,
  output reg primary_osc_enable_out,
  output reg watchdog_reset_out,
  output reg [1:0] power_mode_out,
  output reg [`CAUSE_W-1:0] reset_cause_out,
  output wire [7:0] reset_control_reg_out
);
  localparam S_RESET = 3'h0;
  localparam S_HOLD = 3'h1;
  localparam S_RUN = 3'h2;
  localparam S_IDLE = 3'h3;
  localparam S_WAKE = 3'h4;
  // Delay lengths cut on purpose to the counter width.
  localparam integer OST_INT = `OST_CYCLES;
  localparam integer OST_PLL_INT = `OST_CYCLES + `PLL_CYCLES;
  localparam integer PREP_INT = `PREP_CYCLES;
  localparam integer SETTLE_INT = `SETTLE_CYCLES;
  localparam [`CNT_W-1:0] OST_LEN = OST_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] OST_PLL_LEN = OST_PLL_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] PREP_LEN = PREP_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] SETTLE_LEN = SETTLE_INT[`CNT_W-1:0];
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] master_clear_pin_sync;
  reg master_clear_pin_low;
  reg [7:0] reset_control_reg;
  reg ost_load;
  reg prep_load;
  reg settle_load;
  reg [`CNT_W-1:0] ost_count;
  reg wait_primary;
  reg wait_prep;
  reg wake_internal_run;
  wire ost_done;
  wire prep_done;
  wire settle_done;
  wire crystal_like;
  wire pll_mode;
  wire early_start;
  wire soft_reset;
  wire any_reset;
  assign crystal_like = (primary_cfg_in == `PCLK_CRYSTAL) || (primary_cfg_in == `PCLK_HS_CRYSTAL)
    || pll_mode;
  assign pll_mode = (primary_cfg_in == `PCLK_CRYSTAL_PLL) || (primary_cfg_in == `PCLK_HS_PLL);
  assign early_start = two_speed_en_in || fail_safe_en_in; // RL4
  assign soft_reset = reset_instr_in || stack_full_in || stack_underflow_in;
  assign any_reset = por_event_in || master_clear_pin_low || soft_reset || brownout_event_in
    || (watchdog_expire_in && state == S_RUN); // RL2
  assign reset_control_reg_out = reset_control_reg; // RL13
  // Master clear pin synchroniser; a change counts once stages two and three agree.
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      master_clear_pin_sync <= 3'h7;
      master_clear_pin_low <= 1'b0;
    end else begin
      master_clear_pin_sync <= {master_clear_pin_sync[1:0], master_clear_pin_n_in};
      if (master_clear_pin_sync[1] == master_clear_pin_sync[2]) begin
        master_clear_pin_low <= ~master_clear_pin_sync[2];
      end
    end
  end
  // Start-up timer length, with PLL lock added for PLL modes.
  always @* begin
    if (pll_mode) begin
      ost_count = OST_PLL_LEN; // RL9
    end else begin
      ost_count = OST_LEN;
    end
  end
  delay_counter u_ost (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(ost_load),
    .count_in(ost_count),
    .done_out(ost_done)
  );
  delay_counter u_prep (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(prep_load),
    .count_in(PREP_LEN),
    .done_out(prep_done)
  );
  delay_counter u_settle (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(settle_load),
    .count_in(SETTLE_LEN),
    .done_out(settle_done)
  );
  // Next-state logic.
  always @* begin
    next_state = state;
    case (state)
      S_RESET: begin
        if (!any_reset) begin
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        if (any_reset) begin
          next_state = S_RESET;
        end else if (!crystal_like || early_start || ost_done) begin
          next_state = S_RUN; // RL3
        end
      end
      S_RUN: begin
        if (any_reset) begin
          next_state = S_RESET;
        end else if (sleep_cmd_in) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (any_reset) begin
          next_state = S_RESET;
        end else if (watchdog_expire_in || wake_irq_in) begin
          next_state = S_WAKE; // RL1
        end
      end
      S_WAKE: begin
        if (any_reset) begin
          next_state = S_RESET;
        end else if (prep_done && (!wait_prep || wake_internal_run || early_start)) begin
          next_state = S_RUN; // RL7
        end else if (prep_done && ost_done) begin
          next_state = S_RUN; // RL8
        end
      end
      default: begin
        next_state = S_RESET;
      end
    endcase
  end
  // Delay starts on state entry.
  always @* begin
    ost_load = 1'b0;
    prep_load = 1'b0;
    settle_load = 1'b0;
    if (state == S_RESET && next_state == S_HOLD && crystal_like) begin
      ost_load = 1'b1; // RL3
    end
    if (state == S_IDLE && next_state == S_WAKE) begin
      prep_load = 1'b1; // RL8
      if (power_mode_out != `PM_PRIMARY_IDLE_MODE && clock_select_bits_in == `SEL_PRIMARY
        && crystal_like) begin
        ost_load = 1'b1; // RL6
      end
      if (run_clock_out == `SEL_SECONDARY && clock_select_bits_in == `SEL_INTERNAL) begin
        settle_load = 1'b1; // RL10
      end
    end
  end
  // Sequencer state and core controls.
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= S_RESET;
      core_run_out <= 1'b0;
      core_reset_out <= 1'b1;
      run_clock_out <= `SEL_PRIMARY;
      primary_clock_ready_flag_out <= 1'b0;
      primary_osc_enable_out <= 1'b1;
      watchdog_reset_out <= 1'b0;
      power_mode_out <= `PM_RUN;
      wait_primary <= 1'b0;
      wait_prep <= 1'b0;
      wake_internal_run <= 1'b0;
    end else begin
      state <= next_state;
      watchdog_reset_out <= watchdog_expire_in && state == S_RUN; // RL2
      core_reset_out <= next_state == S_RESET || next_state == S_HOLD;
      core_run_out <= next_state == S_RUN;
      if (ost_load) begin
        wait_primary <= 1'b1;
      end
      if (next_state == S_RESET) begin
        primary_osc_enable_out <= 1'b1;
        primary_clock_ready_flag_out <= 1'b0;
        power_mode_out <= `PM_RUN;
        wait_primary <= 1'b0;
      end
      if (state == S_HOLD && next_state == S_RUN) begin
        if (crystal_like && !ost_done) begin
          run_clock_out <= `SEL_INTERNAL; // RL4
        end else begin
          run_clock_out <= `SEL_PRIMARY;
          primary_clock_ready_flag_out <= 1'b1; // RL3
          wait_primary <= 1'b0;
        end
      end
      if (state == S_RUN && wait_primary && ost_done) begin
        run_clock_out <= `SEL_PRIMARY; // RL5
        primary_clock_ready_flag_out <= 1'b1;
        wait_primary <= 1'b0;
      end
      if (state == S_RUN && next_state == S_IDLE) begin
        if (idle_enable_in && clock_select_bits_in == `SEL_PRIMARY
          && !wait_primary) begin
          power_mode_out <= `PM_PRIMARY_IDLE_MODE;
        end else if (idle_enable_in) begin
          power_mode_out <= `PM_IDLE_OTHER;
        end else begin
          power_mode_out <= `PM_SLEEP;
        end
        if (wait_primary || !idle_enable_in || clock_select_bits_in != `SEL_PRIMARY) begin
          primary_osc_enable_out <= 1'b0; // RL5
          primary_clock_ready_flag_out <= 1'b0;
          wait_primary <= 1'b0;
        end
      end
      if (state == S_IDLE && next_state == S_WAKE) begin
        run_clock_out <= clock_select_bits_in; // RL15
        wait_prep <= ost_load;
        wake_internal_run <= settle_load;
        if (clock_select_bits_in == `SEL_PRIMARY) begin
          primary_osc_enable_out <= 1'b1;
        end
      end
      if (state == S_WAKE && next_state == S_RUN) begin
        power_mode_out <= `PM_RUN;
        if (wait_prep && !ost_done) begin
          run_clock_out <= `SEL_INTERNAL; // RL4
          wait_primary <= 1'b1;
        end else if (run_clock_out == `SEL_PRIMARY) begin
          primary_clock_ready_flag_out <= 1'b1;
        end
        wait_prep <= 1'b0;
        wake_internal_run <= 1'b0;
      end
    end
  end
  // Reset cause record and reset control register; power-on is captured every cycle it is present, other flags in the cycle a reset is taken, not while it is held.
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reset_control_reg <= `RC_RESET_VALUE;
      reset_cause_out <= `CAUSE_POWER_ON;
    end else if (por_event_in) begin
      reset_control_reg[`RC_POWERON] <= 1'b0; // RL12
      reset_control_reg[`RC_BROWNOUT] <= 1'b0;
      reset_cause_out <= `CAUSE_POWER_ON; // RL11
    end else if (any_reset && state != S_RESET) begin
      if (brownout_event_in) begin
        reset_control_reg[`RC_BROWNOUT] <= 1'b0; // RL17
        reset_cause_out <= `CAUSE_BROWNOUT;
      end else if (master_clear_pin_low) begin
        reset_cause_out <= (state == S_IDLE || state == S_WAKE) ? `CAUSE_MASTER_CLEAR_PIN_PM
          : `CAUSE_MASTER_CLEAR_PIN_RUN; // RL11
      end else if (watchdog_expire_in && state == S_RUN) begin
        reset_control_reg[`RC_TIMEOUT] <= 1'b0; // RL12
        reset_cause_out <= `CAUSE_WATCHDOG;
      end else if (reset_instr_in) begin
        reset_control_reg[`RC_RESET_INSTR] <= 1'b0; // RL12
        reset_cause_out <= `CAUSE_RESET_INSTR;
      end else if (stack_full_in) begin
        reset_cause_out <= `CAUSE_STACK_FULL;
      end else begin
        reset_cause_out <= `CAUSE_STACK_UNDER;
      end
    end else if (state == S_IDLE && watchdog_expire_in) begin
      reset_control_reg[`RC_TIMEOUT] <= 1'b0; // RL12
    end else if (state == S_RUN && next_state == S_IDLE) begin
      reset_control_reg[`RC_POWERDOWN] <= 1'b0;
    end else if (reset_control_reg_wr_in) begin
      reset_control_reg[`RC_IRQ_PRIORITY_ENABLE] <= reset_control_reg_wdata_in[`RC_IRQ_PRIORITY_ENABLE]; // RL14
      reset_control_reg[`RC_SW_BROWNOUT_ENABLE] <= reset_control_reg_wdata_in[`RC_SW_BROWNOUT_ENABLE] & sbor_available_in;
      reset_control_reg[`RC_UNUSED] <= 1'b0;
      reset_control_reg[`RC_RESET_INSTR] <= reset_control_reg_wdata_in[`RC_RESET_INSTR]; // RL12
      reset_control_reg[`RC_POWERON] <= reset_control_reg_wdata_in[`RC_POWERON];
      reset_control_reg[`RC_BROWNOUT] <= reset_control_reg_wdata_in[`RC_BROWNOUT];
    end
  end
endmodule // wake_reset_sequencer

// file: tb/wake_seq_props.sv
// Checker for wake latency, watchdog handling and reset flag upkeep.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/1ns
`include "wake_seq_consts.vh"
module wake_seq_props (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire por_event_in,
  input wire brownout_event_in,
  input wire reset_instr_in,
  input wire watchdog_expire_in,
  input wire wake_irq_in,
  input wire sleep_cmd_in,
  input wire reset_control_reg_wr_in,
  input wire [`PCLK_W-1:0] primary_cfg_in,
  input wire core_run_out,
  input wire [1:0] run_clock_out,
  input wire primary_clock_ready_flag_out,
  input wire watchdog_reset_out,
  input wire [1:0] power_mode_out,
  input wire [7:0] reset_control_reg_out
);
  reg [2:0] quiet;
  wire stir = reset_control_reg_wr_in | por_event_in | brownout_event_in | reset_instr_in |
    watchdog_expire_in | sleep_cmd_in | wake_irq_in | !core_run_out;
  // Counts cycles of running with nothing that may touch the flags.
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) quiet <= 3'h0;
    else if (stir) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  a_wdt_run_reset: assert property ((watchdog_expire_in && core_run_out &&
    power_mode_out == `PM_RUN) |-> ##[0:3] watchdog_reset_out) else $error("no watchdog reset");
  a_wdt_pm_wake: assert property ((watchdog_expire_in && power_mode_out != `PM_RUN)
    |-> !watchdog_reset_out [*4]) else $error("watchdog reset in power mode");
  a_wake_prep_min: assert property ((wake_irq_in && power_mode_out != `PM_RUN)
    |-> !core_run_out [*8]) else $error("wake too early");
  a_wake_prep_bound: assert property ((wake_irq_in && power_mode_out == `PM_PRIMARY_IDLE_MODE)
    |-> ##[10:20] core_run_out) else $error("idle wake too late");
  a_ready_primary: assert property ((core_run_out && run_clock_out == `SEL_PRIMARY &&
    primary_cfg_in <= `PCLK_HS_PLL) |-> primary_clock_ready_flag_out) else $error("run unready");
  a_pd_on_sleep: assert property ((sleep_cmd_in && core_run_out && power_mode_out == `PM_RUN)
    |-> ##[1:3] !reset_control_reg_out[`RC_POWERDOWN]) else $error("power-down flag kept");
  a_wdt_to_flag: assert property ((watchdog_expire_in && core_run_out &&
    power_mode_out == `PM_RUN) |-> ##[1:3] !reset_control_reg_out[`RC_TIMEOUT])
    else $error("timeout flag kept");
  a_flags_hold: assert property (quiet == 3'h7 |=> $stable(reset_control_reg_out))
    else $error("flags moved");
endmodule // wake_seq_props
bind wake_reset_sequencer wake_seq_props u_props (.*);

// file: tb/core_model.sv
// Model of the processor core: it times how long it was kept stopped.
// Assumes wake events and run level share the sequencer's clock.
`timescale 1ns/1ns
module core_model (
  input wire mclk_in,
  input wire sys_rst_in,
  input wire core_run_in,
  input wire wake_in,
  output reg [15:0] stall_out
);
  // Restarts on a wake event, counts while stopped, holds while running.
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) stall_out <= 16'h0;
    else if (wake_in) stall_out <= 16'h0;
    else if (!core_run_in) stall_out <= stall_out + 16'h1;
  end
endmodule // core_model

// file: tb/wake_reset_sequencer_tb_top.sv
// Testbench for the sequencer, with the core model on its far side.
// Assumes the constants header is on the include path.
`timescale 1ns/1ns
`include "wake_seq_consts.vh"
module wake_reset_sequencer_tb_top;
  reg mclk_in = 1'b0, sys_rst_in = 1'b1, por = 1'b0, bor = 1'b0, master_clear_pin_n = 1'b1, ri = 1'b0;
  reg sf = 1'b0, su = 1'b0, wdt = 1'b0, wake = 1'b0, slp = 1'b0, idle = 1'b1, ts = 1'b0;
  reg wr = 1'b0, sbor = 1'b1, wdt_seen = 1'b0;
  reg [1:0] sel = 2'h0;
  reg [2:0] cfg = `PCLK_EXTERNAL;
  reg [7:0] wdata = 8'hff;
  wire run, hold, rdy, osc, wres;
  wire [1:0] rclk, pm;
  wire [2:0] cause;
  wire [7:0] rc;
  wire [15:0] stall;
  integer failures = 0, checks = 0, cycles = 0, k;
  wake_reset_sequencer DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .por_event_in(por),
    .brownout_event_in(bor), .master_clear_pin_n_in(master_clear_pin_n), .reset_instr_in(ri),
    .stack_full_in(sf), .stack_underflow_in(su), .watchdog_expire_in(wdt), .wake_irq_in(wake),
    .sleep_cmd_in(slp), .idle_enable_in(idle), .clock_select_bits_in(sel), .primary_cfg_in(cfg),
    .two_speed_en_in(ts), .fail_safe_en_in(1'b0), .reset_control_reg_wr_in(wr), .reset_control_reg_wdata_in(wdata),
    .sbor_available_in(sbor), .core_run_out(run), .core_reset_out(hold), .run_clock_out(rclk),
    .primary_clock_ready_flag_out(rdy), .primary_osc_enable_out(osc),
    .watchdog_reset_out(wres), .power_mode_out(pm), .reset_cause_out(cause),
    .reset_control_reg_out(rc));
  core_model u_core (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .core_run_in(run),
    .wake_in(wake | wdt), .stall_out(stall));
  initial forever #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles = cycles + 1;
    if (wres === 1'b1) wdt_seen = 1'b1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
      #1;
    end
  endtask
  task wait_run;
    integer n;
    begin
      n = 0;
      while (run !== 1'b1 && n < 3000) begin
        tick(1);
        n = n + 1;
      end
      if (n == 3000) failures = failures + 1;
    end
  endtask
  task drive(input [3:0] w, input v);
    case (w)
      0: slp = v;
      1: wake = v;
      2: wdt = v;
      3: wr = v;
      4: master_clear_pin_n = !v;
      5: bor = v;
      6: ri = v;
      7: sf = v;
      8: su = v;
      default: por = v;
    endcase
  endtask
  task pulse(input [3:0] w, input integer n);
    begin
      drive(w, 1'b1);
      tick(n);
      drive(w, 1'b0);
      tick(1);
    end
  endtask
  task restart(input [2:0] c, input t);
    begin
      sys_rst_in = 1'b1;
      cfg = c;
      ts = t;
      tick(2);
      sys_rst_in = 1'b0;
      wait_run;
    end
  endtask
  initial begin
    tick(2);
    sys_rst_in = 1'b0;
    wait_run;
    check(stall <= 16'h4, 1'b1);
    check(rc, 8'h5c);
    check(cause, `CAUSE_POWER_ON);
    restart(`PCLK_CRYSTAL, 1'b0);
    check(stall >= 16'd1024, 1'b1);
    check(rdy, 1'b1);
    pulse(0, 1);
    check(pm, `PM_PRIMARY_IDLE_MODE);
    pulse(1, 1);
    wait_run;
    check(stall >= 16'd10 && stall <= 16'd20, 1'b1);
    idle = 1'b0;
    pulse(0, 1);
    check(pm, `PM_SLEEP);
    check(rc[`RC_POWERDOWN], 1'b0);
    pulse(2, 1);
    wait_run;
    check(stall >= 16'd1024 && stall <= 16'd1032, 1'b1);
    check(wdt_seen, 1'b0);
    check({pm, rclk}, {`PM_RUN, `SEL_PRIMARY});
    restart(`PCLK_CRYSTAL_PLL, 1'b0);
    check(stall >= 16'd1224 && stall <= 16'd1232, 1'b1);
    restart(`PCLK_CRYSTAL, 1'b1);
    check(stall <= 16'h4, 1'b1);
    check({rclk, rdy}, {`SEL_INTERNAL, 1'b0});
    tick(1100);
    check({rclk, rdy}, {`SEL_PRIMARY, 1'b1});
    restart(`PCLK_CRYSTAL, 1'b1);
    pulse(0, 1);
    check(osc, 1'b0);
    pulse(1, 1);
    wait_run;
    restart(`PCLK_EXTERNAL, 1'b0);
    idle = 1'b1;
    sel = `SEL_INTERNAL;
    pulse(0, 1);
    pulse(1, 1);
    wait_run;
    check(stall <= 16'd20, 1'b1);
    check(rclk, `SEL_INTERNAL);
    sel = `SEL_SECONDARY;
    pulse(0, 1);
    pulse(1, 1);
    wait_run;
    check(rclk, `SEL_SECONDARY);
    sel = `SEL_INTERNAL;
    pulse(0, 1);
    pulse(1, 1);
    wait_run;
    check(stall <= 16'd20, 1'b1);
    check(rclk, `SEL_INTERNAL);
    sel = `SEL_PRIMARY;
    pulse(2, 1);
    check(wdt_seen, 1'b1);
    check(rc[`RC_TIMEOUT], 1'b0);
    check(cause, `CAUSE_WATCHDOG);
    wait_run;
    pulse(3, 1);
    check(rc, 8'hd3);
    tick(20);
    check(rc, 8'hd3);
    for (k = 4; k < 10; k = k + 1) begin
      pulse(k[3:0], 6);
      check({run, hold}, 2'h1);
      wait_run;
      check(cause, k == 4 ? `CAUSE_MASTER_CLEAR_PIN_RUN : k == 9 ? `CAUSE_POWER_ON : k - 1);
      if (k == 5) check(rc[1:0], 2'h2);
      if (k == 6) check(rc[`RC_RESET_INSTR], 1'b0);
      pulse(3, 1);
    end
    pulse(0, 1);
    pulse(4, 6);
    wait_run;
    check(cause, `CAUSE_MASTER_CLEAR_PIN_PM);
    finish_test;
  end
endmodule // wake_reset_sequencer_tb_top
